// File: core/pse_map.vh
`ifndef PSE_MAP_VH
`define PSE_MAP_VH
// ==========================================================
// clock
`define PSE_CLK_MHZ 100
// ==========================================================
// times in their own units
`define PSE_BACKOFF_MS 400
`define PSE_DGL_NS 2000
`define PSE_DET_STEP_US 10
`define PSE_CLASS_US 20
`define PSE_INRUSH_MS 60
`define PSE_START_MS 60
`define PSE_OVLD_MS 60
`define PSE_POR_US 10
`define PSE_FSS_GAP_US 20
// ==========================================================
// derived cycle counts at 100 mhz, sized to the counters that hold them
`define PSE_BACKOFF_CYC 26'h2625a00
`define PSE_DGL_CYC 12'h0c8
`define PSE_DET_CYC 26'h00003e8
`define PSE_CLASS_CYC 26'h00007d0
`define PSE_INRUSH_CYC 26'h05b8d80
`define PSE_START_CYC 24'h5b8d80
`define PSE_OVLD_CYC 24'h5b8d80
`define PSE_POR_CYC 12'h3e8
`define PSE_FSS_GAP_CYC 12'h7d0
// ==========================================================
// fault timer step sizes
`define PSE_TMR_UP 28'h0000010
`define PSE_TMR_DN 28'h0000001
// ==========================================================
// reset values
`define PSE_RST_STATE 3'h0
`define PSE_RST_ADDR 4'hf
`define PSE_RST_SYNC 47'h7c0000000000
`endif

// File: core/pse_dglitch.v
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser followed by a stability filter
module pse_dglitch #(
  parameter [11:0] CYC = 12'h0c8,
  parameter RST_VAL = 1'b0
) (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // pin and filtered level
  input wire pin_i,
  output wire lvl_o
);
  reg s1_r;
  reg s2_r;
  reg lvl_r;
  reg [11:0] cnt_r;

  // level changes only after CYC stable samples
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      lvl_r <= RST_VAL;
      cnt_r <= 12'h000;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      if (s2_r == lvl_r) begin
        cnt_r <= 12'h000;
      end else if (cnt_r == CYC - 12'h001) begin
        lvl_r <= s2_r;
        cnt_r <= 12'h000;
      end else begin
        cnt_r <= cnt_r + 12'h001;
      end
    end
  end

  assign lvl_o = lvl_r;
endmodule // pse_dglitch

// File: core/pse_port_ctrl.v
`timescale 1ns/1ps
`include "pse_map.vh"
// Behaviour
// RULE1: semiauto, port above 2.5 V: discharge, wait 400 ms before detection
// RULE2: detect with two probe currents, four points; refuse capacitive loads
// RULE3: bias resistor to supply on, except while detecting or powered
// RULE4: gate low on any low supply or after overcurrent timeout
// RULE5: gate low when the port is turned off by manual shutdown
// RULE6: powered and above cut threshold: fault timer counts up, limit on
// RULE7: port off when timer reaches overload time, start time at turn-on
// RULE8: below cut, timer counts down at 1/16; re-enable only at zero
// RULE9: during inrush, lower current limit from supply-to-port voltage
// RULE10: open-drain interrupt pulled low while any interrupt bit set
// RULE11: fast shutdown active high, default low, deglitched 1 to 5 us
// RULE12: fast shutdown turns ports off like the port reset command
// RULE13: 3-bit mode: pulse series selects up to 8 priority levels
// RULE14: deglitched low reset turns ports off, restores power-up state
// RULE15: internal power-on reset independent of the reset pin
// RULE16: separate data in line and open-drain data out line
// RULE17: four address select inputs set the slave address
// RULE18: classification may run on several ports at once
// RULE19: each channel has its own fault timer and shutdown state
module pse_port_ctrl #(
  parameter [25:0] BACKOFF_CYC = `PSE_BACKOFF_CYC,
  parameter [25:0] INRUSH_CYC = `PSE_INRUSH_CYC,
  parameter [23:0] START_CYC = `PSE_START_CYC,
  parameter [23:0] OVLD_CYC = `PSE_OVLD_CYC
) (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  input wire ext_rst_n_i,
  // supplies, from analog comparators
  input wire vdd_ok_i,
  input wire high_voltage_supply_ok_i,
  // per-channel analog status, asynchronous
  input wire [7:0] port_v_above_i,
  input wire [7:0] det_valid_i,
  input wire [7:0] det_cap_load_i,
  input wire [7:0] power_cut_threshold_i,
  input wire [7:0] fold_v_high_i,
  // per-channel control and the semiauto mode bit, same clock
  input wire semiauto_i,
  input wire [7:0] port_enable_i,
  input wire [7:0] manual_off_i,
  input wire [7:0] port_reset_i,
  // fast shutdown
  input wire fast_shutdown_in_i,
  input wire fss_mode3_i,
  input wire [7:0] fss_enable_i,
  input wire [23:0] fss_priority_i,
  // interrupt
  input wire [7:0] int_flags_i,
  output wire int_o,
  output wire int_oe_n_o,
  // serial data lines and address
  input wire serial_data_in_line_i,
  input wire sda_drive_low_i,
  input wire [3:0] bus_address_select_i,
  output wire serial_data_in_sync_o,
  output wire serial_data_out_line_o,
  output wire serial_data_out_line_oe_n_o,
  output wire [3:0] bus_address_o,
  output wire chip_reset_o,
  // per-channel outputs
  output wire [7:0] gate_drive_out_o,
  output wire [7:0] discharge_en_o,
  output wire [7:0] bias_res_en_o,
  output wire [7:0] probe_en_o,
  output wire [7:0] probe_hi_o,
  output wire [7:0] meas_strobe_o,
  output wire [7:0] class_meas_o,
  output wire [7:0] current_limit_level_o,
  output wire [7:0] foldback_en_o,
  output wire [7:0] port_on_o,
  output wire [7:0] fault_o
);
  // ==========================================================
  // states and counts
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_BACKOFF = 3'h1;
  localparam [2:0] ST_DETECT = 3'h2;
  localparam [2:0] ST_CLASS = 3'h3;
  localparam [2:0] ST_INRUSH = 3'h4;
  localparam [2:0] ST_ON = 3'h5;
  localparam [2:0] ST_COOL = 3'h6;
  localparam [11:0] DGL_CYC = `PSE_DGL_CYC;
  localparam [25:0] DET_CYC = `PSE_DET_CYC;
  localparam [25:0] CLASS_CYC = `PSE_CLASS_CYC;
  localparam [11:0] POR_CYC = `PSE_POR_CYC;
  localparam [11:0] GAP_CYC = `PSE_FSS_GAP_CYC;

  // ==========================================================
  // input synchronisers
  wire [46:0] raw_in;
  reg [46:0] s1_r;
  reg [46:0] s2_r;
  assign raw_in = {serial_data_in_line_i, bus_address_select_i, high_voltage_supply_ok_i, vdd_ok_i,
                   fold_v_high_i, power_cut_threshold_i, det_cap_load_i, det_valid_i,
                   port_v_above_i};
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // data and address pins idle high; a low reset value would fake a start
      s1_r <= `PSE_RST_SYNC;
      s2_r <= `PSE_RST_SYNC;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
    end
  end
  wire [7:0] vhi_s = s2_r[7:0];
  wire [7:0] val_s = s2_r[15:8];
  wire [7:0] cap_s = s2_r[23:16];
  wire [7:0] cut_s = s2_r[31:24];
  wire [7:0] fold_s = s2_r[39:32];
  wire sup_low = ~s2_r[40] | ~s2_r[41];
  wire [3:0] addr_s = s2_r[45:42];
  wire sda_s = s2_r[46];

  // ==========================================================
  // power-on reset and external reset
  reg [11:0] por_cnt_r;
  wire por_busy = (por_cnt_r != POR_CYC);
  wire ext_rst_lvl;
  wire int_rst;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      por_cnt_r <= 12'h000;
    end else if (por_busy) begin
      por_cnt_r <= por_cnt_r + 12'h001; // RULE15
    end
  end
  // pin idles high, as its pull-up would hold it
  pse_dglitch #(.CYC(DGL_CYC), .RST_VAL(1'b1)) u_rst_dgl (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(ext_rst_n_i),
    .lvl_o(ext_rst_lvl)
  );
  assign int_rst = por_busy | ~ext_rst_lvl; // RULE14
  assign chip_reset_o = int_rst;

  // ==========================================================
  // fast shutdown decoding
  wire fss_lvl;
  reg fss_d_r;
  reg fss_pend_r;
  reg [2:0] fss_lvl_r;
  reg [11:0] fss_gap_r;
  reg [7:0] fss_kill_r;
  wire [7:0] fss_sel;
  wire fss_rise = fss_lvl & ~fss_d_r;
  // reset value low stands in for the pull-down
  pse_dglitch #(.CYC(DGL_CYC), .RST_VAL(1'b0)) u_fss_dgl (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(fast_shutdown_in_i),
    .lvl_o(fss_lvl)
  ); // RULE11
  // pulse count closes after a quiet gap; an ninth pulse saturates at level 7
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fss_d_r <= 1'b0;
      fss_pend_r <= 1'b0;
      fss_lvl_r <= 3'h0;
      fss_gap_r <= 12'h000;
      fss_kill_r <= 8'h00;
    end else if (int_rst) begin
      fss_d_r <= fss_lvl;
      fss_pend_r <= 1'b0;
      fss_lvl_r <= 3'h0;
      fss_gap_r <= 12'h000;
      fss_kill_r <= 8'h00;
    end else begin
      fss_d_r <= fss_lvl;
      fss_kill_r <= 8'h00;
      if (!fss_mode3_i) begin
        fss_pend_r <= 1'b0;
        if (fss_rise) begin
          fss_kill_r <= fss_enable_i;
        end
      end else if (fss_rise) begin
        fss_gap_r <= 12'h000;
        fss_pend_r <= 1'b1;
        if (!fss_pend_r) begin
          fss_lvl_r <= 3'h0;
        end else if (fss_lvl_r != 3'h7) begin
          fss_lvl_r <= fss_lvl_r + 3'h1; // RULE13
        end
      end else if (fss_pend_r) begin
        if (fss_gap_r == GAP_CYC - 12'h001) begin
          fss_pend_r <= 1'b0;
          fss_kill_r <= fss_sel; // RULE13
        end else begin
          fss_gap_r <= fss_gap_r + 12'h001;
        end
      end
    end
  end

  // ==========================================================
  // interrupt, data line and address
  reg int_oe_n_r;
  reg sda_oe_n_r;
  reg sda_in_r;
  reg [3:0] addr_r;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      int_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      sda_in_r <= 1'b1;
      addr_r <= `PSE_RST_ADDR;
    end else begin
      int_oe_n_r <= ~(|int_flags_i); // RULE10
      sda_oe_n_r <= int_rst | ~sda_drive_low_i; // RULE16
      sda_in_r <= sda_s; // RULE16
      if (int_rst) begin
        addr_r <= addr_s; // RULE17
      end
    end
  end
  assign int_o = 1'b0;
  assign int_oe_n_o = int_oe_n_r;
  assign serial_data_out_line_o = 1'b0;
  assign serial_data_out_line_oe_n_o = sda_oe_n_r;
  assign serial_data_in_sync_o = sda_in_r;
  assign bus_address_o = addr_r;

  // ==========================================================
  // channel engines
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ch // RULE19
      reg [2:0] st_r;
      reg [2:0] st_nxt;
      reg [25:0] cnt_r;
      reg [25:0] cnt_nxt;
      reg [1:0] step_r;
      reg [1:0] step_nxt;
      reg [27:0] tmr_r;
      reg [27:0] tmr_nxt;
      reg strb_r;
      reg strb_nxt;
      reg flt_r;
      reg flt_nxt;
      reg gate_r;
      wire hot = (st_r == ST_INRUSH) | (st_r == ST_ON);
      wire kill = port_reset_i[g] | fss_kill_r[g]; // RULE12
      wire stop = sup_low | manual_off_i[g] | kill | ~port_enable_i[g];
      wire [27:0] lim = (st_r == ST_INRUSH) ? {START_CYC, 4'h0} : {OVLD_CYC, 4'h0};
      assign fss_sel[g] = fss_enable_i[g] & (fss_priority_i[3*g+2:3*g] <= fss_lvl_r);
      always @* begin
        st_nxt = st_r;
        cnt_nxt = cnt_r + 26'h0000001;
        step_nxt = step_r;
        strb_nxt = 1'b0;
        flt_nxt = 1'b0;
        tmr_nxt = tmr_r;
        // up by 16 when hot and over, otherwise down by 1 until it holds at zero
        if (hot && cut_s[g]) begin
          tmr_nxt = tmr_r + `PSE_TMR_UP; // RULE6
        end else if (tmr_r != 28'h0000000) begin
          tmr_nxt = tmr_r - `PSE_TMR_DN; // RULE8
        end
        case (st_r)
          ST_IDLE: begin
            cnt_nxt = 26'h0000000;
            step_nxt = 2'h0;
            if (!stop) begin
              if (semiauto_i && vhi_s[g]) begin
                st_nxt = ST_BACKOFF; // RULE1
              end else begin
                st_nxt = ST_DETECT;
              end
            end
          end
          ST_BACKOFF: begin
            if (cnt_r == BACKOFF_CYC - 26'h0000001) begin
              cnt_nxt = 26'h0000000;
              st_nxt = ST_DETECT; // RULE1
            end
          end
          ST_DETECT: begin
            if (cnt_r == DET_CYC - 26'h0000001) begin
              cnt_nxt = 26'h0000000;
              strb_nxt = 1'b1; // RULE2
              step_nxt = step_r + 2'h1;
              if (step_r == 2'h3) begin
                // legacy or capacitive signature is never powered
                st_nxt = (val_s[g] && !cap_s[g]) ? ST_CLASS : ST_IDLE; // RULE2
              end
            end
          end
          ST_CLASS: begin
            if (cnt_r == CLASS_CYC - 26'h0000001) begin
              cnt_nxt = 26'h0000000;
              st_nxt = ST_INRUSH; // RULE18
            end
          end
          ST_INRUSH: begin
            if (tmr_r >= lim) begin
              st_nxt = ST_COOL; // RULE7
              flt_nxt = 1'b1;
            end else if (cnt_r == INRUSH_CYC - 26'h0000001) begin
              st_nxt = ST_ON;
            end
          end
          ST_ON: begin
            if (tmr_r >= lim) begin
              st_nxt = ST_COOL; // RULE7
              flt_nxt = 1'b1;
            end
          end
          ST_COOL: begin
            if (tmr_r == 28'h0000000) begin
              st_nxt = ST_IDLE; // RULE8
            end
          end
          default: begin
            st_nxt = ST_COOL;
          end
        endcase
        // stop wins over any forward step
        if (stop && (st_r != ST_IDLE) && (st_r != ST_COOL)) begin
          st_nxt = ST_COOL; // RULE5
        end
      end
      always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          st_r <= `PSE_RST_STATE;
          cnt_r <= 26'h0000000;
          step_r <= 2'h0;
          tmr_r <= 28'h0000000;
          strb_r <= 1'b0;
          flt_r <= 1'b0;
          gate_r <= 1'b0;
        end else if (int_rst) begin
          st_r <= `PSE_RST_STATE; // RULE14
          cnt_r <= 26'h0000000;
          step_r <= 2'h0;
          tmr_r <= 28'h0000000;
          strb_r <= 1'b0;
          flt_r <= 1'b0;
          gate_r <= 1'b0;
        end else begin
          st_r <= st_nxt;
          cnt_r <= cnt_nxt;
          step_r <= step_nxt;
          tmr_r <= tmr_nxt;
          strb_r <= strb_nxt;
          flt_r <= flt_nxt;
          // taken from next state so a low supply drops the gate at once
          gate_r <= (st_nxt == ST_INRUSH) | (st_nxt == ST_ON); // RULE4
        end
      end
      assign gate_drive_out_o[g] = gate_r;
      assign discharge_en_o[g] = (st_r == ST_BACKOFF); // RULE1
      assign bias_res_en_o[g] = ~((st_r == ST_DETECT) | hot); // RULE3
      assign probe_en_o[g] = (st_r == ST_DETECT);
      assign probe_hi_o[g] = (st_r == ST_DETECT) & step_r[1]; // RULE2
      assign meas_strobe_o[g] = strb_r;
      assign class_meas_o[g] = (st_r == ST_CLASS); // RULE18
      assign current_limit_level_o[g] = hot & cut_s[g]; // RULE6
      assign foldback_en_o[g] = (st_r == ST_INRUSH) & fold_s[g]; // RULE9
      assign port_on_o[g] = hot;
      assign fault_o[g] = flt_r;
    end
  endgenerate
endmodule // pse_port_ctrl

// File: test/pse_port_ctrl_properties.sv
`timescale 1ns/1ps
// ==========================================================
// checker beside the port control block
module pse_port_ctrl_properties #(
  parameter [23:0] START_CYC = 24'h032
) (
  // clock, resets, supplies
  input wire clk_i,
  input wire sys_rst_i,
  input wire ext_rst_n_i,
  input wire vdd_ok_i,
  input wire high_voltage_supply_ok_i,
  // controls
  input wire [7:0] manual_off_i,
  input wire fast_shutdown_in_i,
  input wire fss_mode3_i,
  input wire [7:0] fss_enable_i,
  input wire [7:0] int_flags_i,
  // outputs
  input wire int_oe_n_o,
  input wire chip_reset_o,
  input wire [7:0] gate_drive_out_o,
  input wire [7:0] bias_res_en_o,
  input wire [7:0] probe_en_o,
  input wire [7:0] class_meas_o,
  input wire [7:0] port_on_o,
  input wire [7:0] fault_o
);
  reg [27:0] rc_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // drain time left on channel 0; an external reset is not modelled
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      rc_r <= 28'h0;
    else if (fault_o[0])
      rc_r <= {START_CYC, 4'h0};
    else if (rc_r != 28'h0)
      rc_r <= rc_r - 28'h1;
  end
  // ==========================================================
  // assertions
  a_int_level: assert property (
    !$past(sys_rst_i) |-> int_oe_n_o == ~|$past(int_flags_i))
    else $error("interrupt pin not following flags");
  a_supply_low: assert property (
    (!vdd_ok_i || !high_voltage_supply_ok_i) [*6] |-> gate_drive_out_o == 8'h00)
    else $error("gate on with a supply low");
  a_manual_off: assert property (
    (manual_off_i & $past(manual_off_i) & $past(manual_off_i, 2)
      & gate_drive_out_o) == 8'h00)
    else $error("gate on during manual shutdown");
  a_fault_gate: assert property (
    |fault_o |-> (fault_o & gate_drive_out_o) == 8'h00
      ##1 (fault_o & $past(fault_o)) == 8'h00)
    else $error("fault pulse without gate off");
  a_bias_excl: assert property (
    bias_res_en_o == ~(probe_en_o | port_on_o))
    else $error("bias resistor wrong for the port state");
  a_power_order: assert property (
    (gate_drive_out_o & ~$past(gate_drive_out_o) & ~$past(class_meas_o)) == 8'h00)
    else $error("gate raised without classification");
  a_fss_kill: assert property (
    !fss_mode3_i && $rose(fast_shutdown_in_i) ##150 fast_shutdown_in_i
      |-> ##[50:110] (gate_drive_out_o & fss_enable_i) == 8'h00)
    else $error("fast shutdown left a port on");
  a_ext_reset: assert property (
    !ext_rst_n_i [*8] |-> ##[200:215] (gate_drive_out_o | port_on_o) == 8'h00)
    else $error("ports on during external reset");
  a_recover_wait: assert property (
    rc_r > 28'h2 |-> probe_en_o[0] == 1'b0)
    else $error("channel 0 detecting before timer drained");
  a_por_hold: assert property (
    $past(sys_rst_i) |-> chip_reset_o [*8])
    else $error("power-on reset too short");
  c_fault: cover property (|fault_o);
  c_fss3: cover property ($rose(fast_shutdown_in_i) && fss_mode3_i);
  c_class: cover property (&class_meas_o[6:0]);
endmodule // pse_port_ctrl_properties
bind pse_port_ctrl pse_port_ctrl_properties #(.START_CYC(START_CYC)) u_props (.*);

// File: test/pse_far_side.sv
`timescale 1ns/1ps
// ==========================================================
// powered devices and host pins
module pse_far_side (
  // clock and bench commands
  input wire clk_i,
  input wire [7:0] cap_load_i,
  input wire [7:0] overload_i,
  input wire [7:0] precharge_i,
  // device side
  input wire [7:0] gate_i,
  input wire sda_oe_n_i,
  output wire [7:0] v_above_o,
  output wire [7:0] det_valid_o,
  output wire [7:0] det_cap_o,
  output wire [7:0] cut_o,
  output wire [7:0] fold_o,
  output wire sda_line_o,
  output reg fss_o
);
  assign det_valid_o = ~cap_load_i;
  assign det_cap_o = cap_load_i;
  assign v_above_o = gate_i | precharge_i;
  // a short only draws current once the gate is on
  assign cut_o = gate_i & overload_i;
  assign fold_o = gate_i & overload_i;
  // lines tied, pull-up when released
  assign sda_line_o = sda_oe_n_i;
  initial fss_o = 1'b0;
  // rise to rise well under the gap limit
  task pulse_train(input integer k, input integer hi);
    integer j;
    begin
      for (j = 0; j < k; j = j + 1) begin
        @(negedge clk_i);
        fss_o = 1'b1;
        repeat (hi) @(negedge clk_i);
        fss_o = 1'b0;
        repeat (300) @(negedge clk_i);
      end
    end
  endtask
endmodule // pse_far_side

// File: test/test_pse_port_ctrl.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the port control block
module test_pse_port_ctrl;
  localparam [27:0] BACK_N = 28'h0c8;
  // drain: limit 16*50 plus the up-step of the shutoff cycle, then two state steps
  localparam [27:0] TMO_N = 28'h332;
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg ext_rst_n_i = 1'b1;
  reg vdd_ok_i = 1'b1;
  reg high_voltage_supply_ok_i = 1'b1;
  reg semiauto_i = 1'b0;
  reg fss_mode3_i = 1'b0;
  reg sda_drive_low_i = 1'b0;
  reg [7:0] port_enable_i = 8'h00;
  reg [7:0] manual_off_i = 8'h00;
  reg [7:0] port_reset_i = 8'h00;
  reg [7:0] fss_enable_i = 8'h00;
  reg [7:0] int_flags_i = 8'h00;
  reg [23:0] fss_priority_i = 24'hfac688;
  reg [3:0] bus_address_select_i = 4'ha;
  reg [7:0] cap_r = 8'h80;
  reg [7:0] ovl_r = 8'h00;
  reg [7:0] pre_r = 8'h00;
  reg [11:0] rows [0:3];
  wire [7:0] port_v_above_i, det_valid_i, det_cap_load_i, power_cut_threshold_i;
  wire [7:0] fold_v_high_i, gate_drive_out_o, discharge_en_o, bias_res_en_o;
  wire [7:0] probe_en_o, probe_hi_o, meas_strobe_o, class_meas_o, current_limit_level_o;
  wire [7:0] foldback_en_o, port_on_o, fault_o;
  wire fast_shutdown_in_i, serial_data_in_line_i, int_o, int_oe_n_o, serial_data_in_sync_o;
  wire serial_data_out_line_o, serial_data_out_line_oe_n_o, chip_reset_o;
  wire [3:0] bus_address_o;
  integer fail_count = 0;
  integer comparisons = 0;
  integer n;
  integer i;
  always #5 clk_i = ~clk_i;
  pse_port_ctrl #(
    .BACKOFF_CYC(26'h0c8),
    .INRUSH_CYC(26'h0c8),
    .START_CYC(24'h032),
    .OVLD_CYC(24'h032)
  ) dut (.*);
  pse_far_side far (
    .clk_i(clk_i),
    .cap_load_i(cap_r),
    .overload_i(ovl_r),
    .precharge_i(pre_r),
    .gate_i(gate_drive_out_o),
    .sda_oe_n_i(serial_data_out_line_oe_n_o),
    .v_above_o(port_v_above_i),
    .det_valid_o(det_valid_i),
    .det_cap_o(det_cap_load_i),
    .cut_o(power_cut_threshold_i),
    .fold_o(fold_v_high_i),
    .sda_line_o(serial_data_in_line_i),
    .fss_o(fast_shutdown_in_i)
  );
  // ==========================================================
  // compare and report
  task check(input string what, input [27:0] seen, input [27:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task wait_on(input [7:0] want);
    begin
      n = 0;
      while (port_on_o !== want && n < 20000) begin
        @(negedge clk_i);
        n = n + 1;
      end
      check("port on", port_on_o, want);
    end
  endtask
  // ==========================================================
  // about 37k cycles expected; a hang stops well short of 100k
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  initial begin
    // flags, drive low; then int, out-enable, synced in
    rows[0] = 12'h007;
    rows[1] = 12'h018;
    rows[2] = 12'h803;
    rows[3] = 12'hff8;
    repeat (6) @(negedge clk_i);
    check("bias rst", bias_res_en_o, 8'hff);
    check("addr rst", bus_address_o, 4'hf);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    check("por busy", chip_reset_o, 1'b1);
    repeat (1010) @(negedge clk_i);
    check("por done", chip_reset_o, 1'b0);
    check("address", bus_address_o, 4'ha);
    check("int data", int_o, 1'b0);
    check("sda data", serial_data_out_line_o, 1'b0);
    for (i = 0; i < 4; i = i + 1) begin
      {int_flags_i, sda_drive_low_i} = rows[i][11:3];
      repeat (6) @(negedge clk_i);
      check("int oe", int_oe_n_o, rows[i][2]);
      check("sda oe", serial_data_out_line_oe_n_o, rows[i][1]);
      check("sda in", serial_data_in_sync_o, rows[i][0]);
    end
    // ==========================================================
    // all ports at once; port 7 is a capacitive load
    port_enable_i = 8'hff;
    n = 0;
    while (class_meas_o !== 8'h7f && n < 6000) begin
      @(negedge clk_i);
      n = n + 1;
    end
    check("class", class_meas_o, 8'h7f);
    wait_on(8'h7f);
    // overload on port 0 only
    ovl_r = 8'h01;
    repeat (10) @(negedge clk_i);
    check("limit", current_limit_level_o[0], 1'b1);
    check("fold", foldback_en_o, 8'h01);
    n = 0;
    while (fault_o[0] !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n = n + 1;
    end
    check("fault", fault_o[0], 1'b1);
    check("gates", gate_drive_out_o, 8'h7e);
    ovl_r = 8'h00;
    n = 0;
    while (probe_en_o[0] !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n = n + 1;
    end
    check("drain", n >= TMO_N && n < TMO_N + 10, 1'b1);
    check("probe lo", probe_hi_o[0], 1'b0);
    repeat (1000) @(negedge clk_i);
    check("strobe", meas_strobe_o[0], 1'b1);
    repeat (1000) @(negedge clk_i);
    check("probe hi", probe_hi_o[0], 1'b1);
    wait_on(8'h7f);
    manual_off_i = 8'h02;
    repeat (3) @(negedge clk_i);
    check("manual", gate_drive_out_o, 8'h7d);
    manual_off_i = 8'h00;
    high_voltage_supply_ok_i = 1'b0;
    repeat (8) @(negedge clk_i);
    check("supply", gate_drive_out_o, 8'h00);
    high_voltage_supply_ok_i = 1'b1;
    wait_on(8'h7f);
    // charged port 2 in semiauto
    semiauto_i = 1'b1;
    pre_r = 8'h04;
    manual_off_i = 8'h04;
    repeat (3) @(negedge clk_i);
    manual_off_i = 8'h00;
    n = 0;
    while (discharge_en_o[2] !== 1'b1 && n < 50) begin
      @(negedge clk_i);
      n = n + 1;
    end
    n = 0;
    while (discharge_en_o[2] === 1'b1 && n < 1000) begin
      @(negedge clk_i);
      n = n + 1;
    end
    check("backoff", n >= BACK_N - 1 && n <= BACK_N + 1, 1'b1);
    pre_r = 8'h00;
    semiauto_i = 1'b0;
    wait_on(8'h7f);
    // ==========================================================
    // fast shutdown: glitch, 1-bit, then three pulses
    fss_enable_i = 8'h0f;
    far.pulse_train(1, 50);
    check("glitch", port_on_o, 8'h7f);
    far.pulse_train(1, 300);
    check("fss one", port_on_o, 8'h70);
    wait_on(8'h7f);
    fss_mode3_i = 1'b1;
    fss_enable_i = 8'hff;
    far.pulse_train(3, 300);
    repeat (2000) @(negedge clk_i);
    check("fss three", port_on_o, 8'h78);
    port_reset_i = 8'h08;
    @(negedge clk_i);
    port_reset_i = 8'h00;
    @(negedge clk_i);
    check("port reset", port_on_o, 8'h70);
    ext_rst_n_i = 1'b0;
    repeat (300) @(negedge clk_i);
    check("ext gate", gate_drive_out_o, 8'h00);
    check("ext chip", chip_reset_o, 1'b1);
    ext_rst_n_i = 1'b1;
    tally_and_finish;
  end
endmodule // test_pse_port_ctrl
